// File: rtl/svm_pkg.sv
// Package of constants and types for the supply monitor control block
package svm_pkg;
  // ==========================================================================
  // Register map
  localparam logic [15:0] SVM_CTRL_ADDR    = 16'hFFBE; // Monitor control register
  localparam logic [15:0] SVM_LEVEL_ADDR   = 16'hFFBF; // Threshold select register
  localparam logic [7:0]  SVM_CTRL_RST     = 8'h00;    // Control reset value
  localparam logic [7:0]  SVM_LEVEL_RST    = 8'h00;    // Level reset value
  // ==========================================================================
  // Field positions
  localparam int SVM_FLAG_BIT   = 0;                   // Below-threshold flag
  localparam int SVM_MODE_BIT   = 1;                   // Reset or irq select
  localparam int SVM_EN_BIT     = 7;                   // Monitor enable
  localparam int SVM_LEVEL_W    = 4;                   // Level code width
  localparam logic [3:0] SVM_LEVEL_MAX = 4'h9;         // Highest legal code
  // ==========================================================================
  // Timing
  localparam int CLK_MHZ        = 125;                 // System clock rate
  localparam int DIP_MIN_US     = 200;                 // Least persistent dip
  localparam int DIP_CYC        = DIP_MIN_US * CLK_MHZ; // Filter length in cycles
  localparam int DIP_CNT_W      = $clog2(DIP_CYC + 1); // Filter counter width
  // ==========================================================================
  // Reset source classes
  typedef enum logic [1:0] {
    SVM_RST_NONE,      // No reset this cycle
    SVM_RST_MONITOR,   // Reset caused by this monitor
    SVM_RST_OTHER      // Any other reset, incl. default start
  } svm_rst_e;
endpackage : svm_pkg

// File: rtl/svm_supply_monitor_ctrl.sv
// Control logic for the on-chip supply voltage monitor
//
// Functional notes
// - Reset mode holds internal reset while low
// - Irq mode pulses irq on both crossings
// - Flag reads 1 only when below, enabled
// - Enable bit 7 gates reset and irq
// - Flag sets after 200 us low dip
// - Other resets clear register; monitor reset keeps
// - Post-reset value follows default-start option
// - Disabling in irq mode while low may irq
// - Monitor reset sets reset-cause bit 0
// - Default-start option enables reset mode
// - Ten software-selectable threshold levels
// - Monitor keeps working in clock-stopped mode
// - Level code at FFBFH, 0 to 9 legal
// - Any reset sets irq mask to 1
`timescale 1ns/100ps
module svm_supply_monitor_ctrl
  import svm_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         monitorResetIn,
  input  wire logic                         defaultStartOption,
  input  wire logic                         compBelowAsync,
  input  wire logic [15:0]                  regAddr,
  input  wire logic                         regWrite,
  input  wire logic                         regRead,
  input  wire logic [7:0]                   regWdata,
  input  wire logic                         irqMaskWrite,
  input  wire logic                         irqMaskWdata,
  input  wire logic                         irqPendingClear,
  input  wire logic                         resetCauseClear,
  output logic      [7:0]                   regRdata,
  output logic      [svm_pkg::SVM_LEVEL_W-1:0] detectThreshold,
  output logic                              comparatorEnable,
  output logic                              internalResetReq,
  output logic                              undervoltageIrq,
  output logic                              undervoltageIrqPending,
  output logic                              undervoltageIrqMask,
  output logic                              undervoltageResetCause
);
  import svm_pkg::*;

  // ==========================================================================
  // Reset source decode
  // Monitor-caused reset is signalled from outside; srst alone is any other
  // Only three classes exist; the spare enum code is never produced
  function automatic svm_rst_e rstClass(input logic sr, input logic mr);
    if (sr && !mr) rstClass = SVM_RST_OTHER;
    else if (sr)   rstClass = SVM_RST_MONITOR;
    else           rstClass = SVM_RST_NONE;
  endfunction : rstClass

  svm_rst_e rstKind;                                 // Class of current reset
  assign rstKind = rstClass(srst, monitorResetIn);

  // ==========================================================================
  // State
  logic                   sync1_q, sync1_d;          // First sync stage
  logic                   sync2_q, sync2_d;          // Second sync stage
  logic                   lowPrev_q, lowPrev_d;      // Filtered level, last cycle
  logic [DIP_CNT_W-1:0]   dipCnt_q, dipCnt_d;        // Low-duration counter
  logic                   flag_q, flag_d;            // Filtered below level
  logic                   enable_q, enable_d;        // Monitor enable
  logic                   mode_q, mode_d;            // 1 reset, 0 irq
  logic [SVM_LEVEL_W-1:0] level_q, level_d;          // Threshold code
  logic                   rstReq_q, rstReq_d;        // Internal reset request
  logic                   irq_q, irq_d;              // One-cycle irq pulse
  logic                   pend_q, pend_d;            // Irq pending flag
  logic                   mask_q, mask_d;            // Irq mask
  logic                   cause_q, cause_d;          // Monitor reset cause
  logic [7:0]             rdata_q, rdata_d;          // Read data register
  logic                   ctrlWr, levelWr;           // Decoded writes
  logic                   flagRise, flagFall;        // Filtered edges

  // Address decode; only exact matches take a write
  assign ctrlWr  = regWrite && (regAddr == SVM_CTRL_ADDR);
  assign levelWr = regWrite && (regAddr == SVM_LEVEL_ADDR);
  // Edges of the filtered level, not of the raw comparator
  assign flagRise = flag_q && !lowPrev_q;
  assign flagFall = !flag_q && lowPrev_q;

  // ==========================================================================
  // Comparator path: synchroniser and dip filter
  // The 200 us filter trades response time for immunity to short glitches
  always_comb begin
    sync1_d   = compBelowAsync;
    sync2_d   = sync1_q;
    lowPrev_d = flag_q;
    dipCnt_d  = dipCnt_q;
    flag_d    = flag_q;
    if (!enable_q) begin                             // Disabled: flag cleared
      dipCnt_d = '0;
      flag_d   = 1'b0;
    end else if (!sync2_q) begin                     // Supply good: release at once
      dipCnt_d = '0;
      flag_d   = 1'b0;
    end else if (dipCnt_q < DIP_CNT_W'(DIP_CYC - 1)) begin
      dipCnt_d = dipCnt_q + 1'b1;                    // Count persistent dip
    end else begin
      flag_d   = 1'b1;
    end
  end

  // Sync stages carry no reset: they flush within two cycles
  always_ff @(posedge clk) begin
    sync1_q   <= sync1_d;
    sync2_q   <= sync2_d;
    if (srst) begin
      lowPrev_q <= 1'b0;
      dipCnt_q  <= '0;
      flag_q    <= 1'b0;
    end else begin
      lowPrev_q <= lowPrev_d;
      dipCnt_q  <= dipCnt_d;
      flag_q    <= flag_d;
    end
  end

  // ==========================================================================
  // Control and level registers
  // The default-start option only steers values at a non-monitor reset
  always_comb begin
    enable_d = enable_q;
    mode_d   = mode_q;
    level_d  = level_q;
    unique case (rstKind)
      SVM_RST_OTHER: begin                           // Clear, or default start
        enable_d = defaultStartOption;
        mode_d   = defaultStartOption;
        level_d  = SVM_LEVEL_RST[SVM_LEVEL_W-1:0];
      end
      SVM_RST_MONITOR: begin                         // Hold contents
      end
      SVM_RST_NONE: begin
        if (ctrlWr) begin                            // Only bits 7 and 1 writable
          enable_d = regWdata[SVM_EN_BIT];
          mode_d   = regWdata[SVM_MODE_BIT];
        end
        if (levelWr && regWdata[SVM_LEVEL_W-1:0] <= SVM_LEVEL_MAX) begin
          level_d = regWdata[SVM_LEVEL_W-1:0];       // Illegal codes dropped
        end
      end
    endcase
  end

  // Control state only registers; reset classes are decided above
  always_ff @(posedge clk) begin
    enable_q <= enable_d;
    mode_q   <= mode_d;
    level_q  <= level_d;
  end

  // ==========================================================================
  // Reset, interrupt and cause generation
  // No clock gating here, so it keeps running in the clock-stopped mode
  always_comb begin
    rstReq_d = enable_q && mode_q && flag_q;
    irq_d    = 1'b0;
    if (enable_q && !mode_q && (flagRise || flagFall)) begin
      irq_d = 1'b1;                                  // Both crossings
    end else if (ctrlWr && enable_q && !mode_q && flag_q
                 && !regWdata[SVM_EN_BIT]) begin
      irq_d = 1'b1;                                  // Disable while low
    end
    pend_d = pend_q;
    if (irqPendingClear) pend_d = 1'b0;
    if (irq_d)           pend_d = 1'b1;              // Set wins over clear
    mask_d = irqMaskWrite ? irqMaskWdata : mask_q;
    cause_d = cause_q;
    if (resetCauseClear) cause_d = 1'b0;
    if (rstReq_q)        cause_d = 1'b1;
    rdata_d = 8'h00;                                 // Unused bits read zero
    if (regRead && regAddr == SVM_CTRL_ADDR) begin
      rdata_d[SVM_EN_BIT]   = enable_q;
      rdata_d[SVM_MODE_BIT] = mode_q;
      rdata_d[SVM_FLAG_BIT] = flag_q;
    end else if (regRead && regAddr == SVM_LEVEL_ADDR) begin
      rdata_d[SVM_LEVEL_W-1:0] = level_q;
    end
  end

  // Outputs reset on any reset; the cause bit survives a monitor reset
  always_ff @(posedge clk) begin
    if (srst) begin
      rstReq_q <= 1'b0;
      irq_q    <= 1'b0;
      pend_q   <= 1'b0;
      mask_q   <= 1'b1;                              // Masked after any reset
      rdata_q  <= 8'h00;
    end else begin
      rstReq_q <= rstReq_d;
      irq_q    <= irq_d;
      pend_q   <= pend_d;
      mask_q   <= mask_d;
      rdata_q  <= rdata_d;
    end
    if (rstKind == SVM_RST_OTHER) begin
      cause_q <= 1'b0;                               // Other resets clear cause
    end else begin
      cause_q <= cause_d;                            // Kept across own reset
    end
  end

  // ==========================================================================
  // Outputs
  // Software owns the 10 us settle wait; no hardware blanking is added
  assign regRdata               = rdata_q;
  assign detectThreshold        = level_q;
  assign comparatorEnable       = enable_q;
  assign internalResetReq       = rstReq_q;
  assign undervoltageIrq        = irq_q;
  assign undervoltageIrqPending = pend_q;
  assign undervoltageIrqMask    = mask_q;
  assign undervoltageResetCause = cause_q;
endmodule : svm_supply_monitor_ctrl

// File: verif/svm_ctrl_properties.sv
// Port-level assertions for the supply monitor control block
`timescale 1ns/100ps
module svm_ctrl_properties
  import svm_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [15:0] regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regWdata,
  input wire logic [7:0]  regRdata,
  input wire logic [3:0]  detectThreshold,
  input wire logic        comparatorEnable,
  input wire logic        internalResetReq,
  input wire logic        undervoltageIrq,
  input wire logic        undervoltageIrqPending,
  input wire logic        undervoltageIrqMask,
  input wire logic        undervoltageResetCause
);
  // ==========================================================================
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================================
  // Assertions
  a_mask_after_reset: assert property ($past(srst) |-> undervoltageIrqMask)
    else $error("irq mask not set after reset");
  a_irq_single_pulse: assert property (undervoltageIrq |=> !undervoltageIrq)
    else $error("irq pulse longer than one cycle");
  a_irq_sets_pending: assert property (undervoltageIrq |-> ##[0:1] undervoltageIrqPending)
    else $error("irq did not set pending");
  a_cause_on_reset: assert property (internalResetReq |-> ##[0:1] undervoltageResetCause)
    else $error("reset cause not set");
  // Three cycles allow the one late pulse that disabling may give
  a_idle_when_off: assert property (!comparatorEnable [*3] |->
    !undervoltageIrq && !internalResetReq)
    else $error("activity while disabled");
  a_ctrl_readback: assert property (regRead && regAddr == SVM_CTRL_ADDR |=>
    regRdata[7] == $past(comparatorEnable) && regRdata[6:2] == 5'h00)
    else $error("control readback wrong");
  a_level_readback: assert property (regRead && regAddr == SVM_LEVEL_ADDR |=>
    regRdata == {4'h0, $past(detectThreshold)})
    else $error("level readback wrong");
  a_level_legal: assert property (detectThreshold <= SVM_LEVEL_MAX)
    else $error("prohibited level code held");
  a_disable_write: assert property (regWrite && regAddr == SVM_CTRL_ADDR && !regWdata[7]
    |=> !comparatorEnable)
    else $error("enable stayed on after clear");
  // ==========================================================================
  // Main scenarios reached
  c_irq: cover property (undervoltageIrq);
  c_reset_req: cover property (internalResetReq);
  c_level_read: cover property (regRead && regAddr == SVM_LEVEL_ADDR);
endmodule : svm_ctrl_properties

bind svm_supply_monitor_ctrl svm_ctrl_properties chk (.clk, .srst, .regAddr, .regWrite,
  .regRead, .regWdata, .regRdata, .detectThreshold, .comparatorEnable, .internalResetReq,
  .undervoltageIrq, .undervoltageIrqPending, .undervoltageIrqMask, .undervoltageResetCause);

// File: verif/test_svm_supply_monitor_ctrl.sv
// Self-checking testbench for the supply monitor control block
`timescale 1ns/100ps
module test_svm_supply_monitor_ctrl;
  import svm_pkg::*;
  logic clk, srst, monitorResetIn, defaultStartOption, compBelowAsync, regWrite, regRead;
  logic irqMaskWrite, irqMaskWdata, irqPendingClear, resetCauseClear, comparatorEnable;
  logic internalResetReq, undervoltageIrq, undervoltageIrqPending, undervoltageIrqMask;
  logic undervoltageResetCause;
  logic [15:0] regAddr;
  logic [7:0] regWdata, regRdata, d;
  logic [3:0] detectThreshold, lvl;   // Level expected in the model
  int miscompares, checks, cycles, irqs, i;
  integer seed;   // Random stream state
  svm_supply_monitor_ctrl uut (.clk, .srst, .monitorResetIn, .defaultStartOption,
    .compBelowAsync, .regAddr, .regWrite, .regRead, .regWdata, .irqMaskWrite, .irqMaskWdata,
    .irqPendingClear, .resetCauseClear, .regRdata, .detectThreshold, .comparatorEnable,
    .internalResetReq, .undervoltageIrq, .undervoltageIrqPending, .undervoltageIrqMask,
    .undervoltageResetCause);
  // ==========================================================================
  // Clock, pulse counter and hang guard
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (undervoltageIrq === 1'b1) irqs++;
    // Three filter waits of 25000 cycles dominate the run
    if (cycles == 90000) begin
      miscompares++;
      stop_test();
    end
  end
  // ==========================================================================
  // Expectations and bus tasks
  function automatic logic [7:0] ctrlExp(input logic [7:0] w);
    return w & 8'h82;   // Flag and reserved bits never take writes
  endfunction : ctrlExp
  function automatic logic [3:0] lvlNext(input logic [3:0] cur, input logic [3:0] w);
    return (w <= 4'h9) ? w : cur;
  endfunction : lvlNext
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [15:0] a, logic [7:0] v);
    @(negedge clk) regAddr = a;
    regWdata = v;
    regWrite = 1;
    @(negedge clk) regWrite = 0;
  endtask : wr
  task automatic rd(logic [15:0] a, logic [7:0] exp, string nm);
    @(negedge clk) regAddr = a;
    regRead = 1;
    @(negedge clk) regRead = 0;
    chk(nm, exp, regRdata);
  endtask : rd
  task automatic waitIrq(int n);
    int s;
    s = irqs;
    for (int k = 0; k < n && irqs == s; k++) @(negedge clk);
    chk("irq pulse", 8'h01, 8'(irqs != s));
  endtask : waitIrq
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // ==========================================================================
  // Main sequence
  initial begin
    {srst, monitorResetIn, defaultStartOption, compBelowAsync, regWrite, regRead} = 6'h20;
    {irqMaskWrite, irqMaskWdata, irqPendingClear, resetCauseClear} = 4'h0;
    {regAddr, regWdata, lvl, seed} = {24'h0, 4'h0, 32'd95886};
    repeat (16) @(negedge clk);
    srst = 0;
    rd(SVM_CTRL_ADDR, 8'h00, "control");
    chk("mask", 8'h01, 8'(undervoltageIrqMask));
    $display("reset test done");
    for (i = 0; i < 24; i++) begin
      // Corners first: every reserved bit, top legal code, first illegal code
      d = (i == 0) ? 8'h7F : (i == 1) ? 8'h09 : (i == 2) ? 8'h0A : 8'($random(seed));
      wr(SVM_CTRL_ADDR, d & 8'h7F);
      rd(SVM_CTRL_ADDR, ctrlExp(d & 8'h7F), "control");
      lvl = lvlNext(lvl, d[3:0]);
      wr(SVM_LEVEL_ADDR, {4'h0, d[3:0]});
      rd(SVM_LEVEL_ADDR, {4'h0, lvl}, "level");
    end
    chk("threshold", {4'h0, lvl}, {4'h0, detectThreshold});
    rd(16'hFFBD, 8'h00, "unmapped");
    $display("register test done");
    wr(SVM_CTRL_ADDR, 8'h80);
    chk("enable", 8'h01, 8'(comparatorEnable));
    repeat (1250) @(negedge clk);   // Settling wait of 10 us
    compBelowAsync = 1;
    waitIrq(25100);
    rd(SVM_CTRL_ADDR, 8'h81, "control");
    chk("pending", 8'h01, 8'(undervoltageIrqPending));
    @(negedge clk) irqPendingClear = 1;
    @(negedge clk) irqPendingClear = 0;
    chk("pending", 8'h00, 8'(undervoltageIrqPending));
    compBelowAsync = 0;
    waitIrq(20);
    rd(SVM_CTRL_ADDR, 8'h80, "control");
    compBelowAsync = 1;
    waitIrq(25100);
    wr(SVM_CTRL_ADDR, 8'h00);
    waitIrq(20);
    chk("enable", 8'h00, 8'(comparatorEnable));
    rd(SVM_CTRL_ADDR, 8'h00, "control");
    $display("interrupt test done");
    wr(SVM_CTRL_ADDR, 8'h82);
    for (i = 0; i < 25100 && !internalResetReq; i++) @(negedge clk);
    chk("reset request", 8'h01, 8'(internalResetReq));
    repeat (2) @(negedge clk);
    chk("reset cause", 8'h01, 8'(undervoltageResetCause));
    compBelowAsync = 0;
    repeat (5) @(negedge clk);
    chk("reset request", 8'h00, 8'(internalResetReq));
    {srst, monitorResetIn} = 2'h3;
    @(negedge clk) {srst, monitorResetIn} = 2'h0;
    rd(SVM_CTRL_ADDR, 8'h82, "control");
    rd(SVM_LEVEL_ADDR, {4'h0, lvl}, "level");
    chk("reset cause", 8'h01, 8'(undervoltageResetCause));
    {resetCauseClear, irqMaskWrite} = 2'h3;
    @(negedge clk) {resetCauseClear, irqMaskWrite} = 2'h0;
    chk("reset cause", 8'h00, 8'(undervoltageResetCause));
    chk("mask", 8'h00, 8'(undervoltageIrqMask));
    {srst, defaultStartOption} = 2'h3;
    repeat (2) @(negedge clk);
    srst = 0;
    rd(SVM_CTRL_ADDR, 8'h82, "control");
    rd(SVM_LEVEL_ADDR, 8'h00, "level");
    chk("mask", 8'h01, 8'(undervoltageIrqMask));
    {srst, defaultStartOption} = 2'h2;
    @(negedge clk) srst = 0;
    rd(SVM_CTRL_ADDR, 8'h00, "control");
    $display("reset source test done");
    stop_test();
  end
endmodule : test_svm_supply_monitor_ctrl
